// File: core/ccpu_defines.vh
`ifndef CCPU_DEFINES_VH
`define CCPU_DEFINES_VH
// register offsets (byte address on the plain port)
`define CCPU_OFF_FLAGS 8'h0C
`define CCPU_OFF_TCOUNT 8'h11
`define CCPU_OFF_TCTRL 8'h12
`define CCPU_OFF_CAPLO 8'h15
`define CCPU_OFF_CAPHI 8'h16
`define CCPU_OFF_UCTRL 8'h17
`define CCPU_OFF_ENABLES 8'h8C
`define CCPU_OFF_PERIOD 8'h92
// field positions
`define CCPU_FLAG_UNIT 2
`define CCPU_FLAG_TIMER 1
`define CCPU_TC_RUN 2
// reset values
`define CCPU_RST_PERIOD 8'hFF
`define CCPU_RST_ZERO 8'h00
// mode codes
`define CCPU_M_OFF 4'h0
`define CCPU_M_CAP_FALL 4'h4
`define CCPU_M_CAP_RISE 4'h5
`define CCPU_M_CAP_R4 4'h6
`define CCPU_M_CAP_R16 4'h7
`define CCPU_M_CMP_HIGH 4'h8
`define CCPU_M_CMP_LOW 4'h9
`define CCPU_M_CMP_SOFT 4'hA
`define CCPU_M_CMP_TRIG 4'hB
`endif

// File: core/ccpu_top.v
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "ccpu_defines.vh"
// Overview of operation
// - bits 6-3 pick postscale 1:1 to 1:16
// - bits 1-0 pick prescale 1, 4, 16
// - control bit 7 reads zero, ignores writes
// - one 16-bit capture/compare/duty register
// - register reached as low and high bytes
// - capture/compare use wide timer, pwm periodic
// - mode 1011 match fires special event trigger
// - mode 0000 turns unit off, resets it
// - pwm duty is low byte plus bits 5-4
// - soft compare mode sets flag only
// - unit control mode in bits 3-0
// - capture copies wide timer, sets flag
// - capture on fall, rise, 4th, 16th rise
// - period match clears timer, sets pin unless duty is zero, loads duty
// - timer counts to period, match feeds postscaler
module ccpu_top (
  input wire ref_clk_in, // 100 MHz clock
  input wire reset_in, // async reset, active high
  input wire [7:0] addr_in, // register address
  input wire [7:0] wdata_in, // write data
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  output reg [7:0] rdata_out, // read data, cycle after rd_in
  input wire pin_in, // capture pin level, asynchronous
  input wire [15:0] wide_timer_count_in, // wide timer value
  output reg pin_out, // compare/pwm output level
  output reg wide_timer_reset_out, // special event: clear wide timer
  output reg adc_start_out, // special event: start conversion
  output reg unit_event_flag_out, // unit event flag
  output reg periodic_timer_flag_out // periodic timer flag
);
  reg [7:0] count_q;
  reg [6:0] tctrl_q;
  reg [7:0] period_q;
  reg [5:0] uctrl_q;
  reg [7:0] cap_lo_q;
  reg [7:0] cap_hi_q;
  reg [1:0] duty_lat_q;
  reg [3:0] pre_q;
  reg [3:0] post_q;
  reg [3:0] cap_pre_q;
  reg [1:0] flags_q;
  reg [1:0] enables_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_s3_q;
  reg pin_q;
  reg [3:0] last_mode_q;
  wire [3:0] mode = uctrl_q[3:0];
  wire is_pwm = (mode[3:2] == 2'b11);
  wire is_cap = (mode[3:2] == 2'b01);
  wire is_cmp = (mode[3:2] == 2'b10);
  wire wr_count = wr_in && (addr_in == `CCPU_OFF_TCOUNT);
  wire wr_tctrl = wr_in && (addr_in == `CCPU_OFF_TCTRL);
  wire wr_uctrl = wr_in && (addr_in == `CCPU_OFF_UCTRL);
  wire wr_flags = wr_in && (addr_in == `CCPU_OFF_FLAGS);
  wire wr_lo = wr_in && (addr_in == `CCPU_OFF_CAPLO);
  wire wr_hi = wr_in && (addr_in == `CCPU_OFF_CAPHI);
  // prescale terminal count: 1, 4 or 16 clocks per tick
  reg [3:0] pre_term;
  always @* begin
    case (tctrl_q[1:0])
      2'b00: pre_term = 4'h0;
      2'b01: pre_term = 4'h3;
      default: pre_term = 4'hF;
    endcase
  end
  wire tick = tctrl_q[`CCPU_TC_RUN] && (pre_q == pre_term);
  wire match = tick && (count_q == period_q);
  wire post_done = match && (post_q == tctrl_q[6:3]);
  // pin edges from the synchronised copy only
  wire rise = pin_s2_q && !pin_s3_q;
  wire fall = !pin_s2_q && pin_s3_q;
  reg cap_evt;
  always @* begin
    case (mode)
      `CCPU_M_CAP_FALL: cap_evt = fall;
      `CCPU_M_CAP_RISE: cap_evt = rise;
      `CCPU_M_CAP_R4: cap_evt = rise && (cap_pre_q[1:0] == 2'h3);
      `CCPU_M_CAP_R16: cap_evt = rise && (cap_pre_q == 4'hF);
      default: cap_evt = 1'b0;
    endcase
  end
  // compare uses the wide timer as time base
  wire cmp_hit = is_cmp && ({cap_hi_q, cap_lo_q} == wide_timer_count_in);
  wire trig = cmp_hit && (mode == `CCPU_M_CMP_TRIG);
  // 10-bit pwm compare: high byte plus latch against count plus prescale
  // the two fine bits are the top two bits of whichever prescale is in use;
  // at prescale 1 the prescaler never leaves zero, so they stay zero
  wire [1:0] pre_fine = tctrl_q[1] ? pre_q[3:2] : pre_q[1:0];
  wire [9:0] pwm_pos = {count_q, pre_fine};
  wire [9:0] duty_now = {cap_hi_q, duty_lat_q};
  wire duty_zero = ({cap_lo_q, uctrl_q[5:4]} == 10'h000);
  // synchroniser for the asynchronous capture pin
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  // periodic timer, prescaler and postscaler
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_q <= `CCPU_RST_ZERO;
      tctrl_q <= 7'h00;
      period_q <= `CCPU_RST_PERIOD;
      pre_q <= 4'h0;
      post_q <= 4'h0;
    end else begin
      if (wr_tctrl)
        tctrl_q <= wdata_in[6:0];
      if (wr_in && addr_in == `CCPU_OFF_PERIOD)
        period_q <= wdata_in;
      // writes to count or control clear both scalers
      if (wr_count || wr_tctrl) begin
        pre_q <= 4'h0;
        post_q <= 4'h0;
      end else begin
        if (tctrl_q[`CCPU_TC_RUN])
          pre_q <= tick ? 4'h0 : pre_q + 4'h1;
        if (match)
          post_q <= post_done ? 4'h0 : post_q + 4'h1;
      end
      if (wr_count)
        count_q <= wdata_in;
      else if (match)
        count_q <= 8'h00;
      else if (tick)
        count_q <= count_q + 8'h01;
    end
  end
  // unit control, capture pair and capture prescaler
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      uctrl_q <= 6'h00;
      cap_lo_q <= 8'h00;
      cap_hi_q <= 8'h00;
      duty_lat_q <= 2'h0;
      cap_pre_q <= 4'h0;
      last_mode_q <= 4'h0;
    end else begin
      last_mode_q <= mode;
      if (wr_uctrl)
        uctrl_q <= wdata_in[5:0];
      if (wr_lo)
        cap_lo_q <= wdata_in;
      // high byte is read-only in pwm mode
      if (wr_hi && !is_pwm)
        cap_hi_q <= wdata_in;
      if (is_cap && cap_evt) begin
        cap_lo_q <= wide_timer_count_in[7:0];
        cap_hi_q <= wide_timer_count_in[15:8];
      end
      if (is_pwm && match) begin
        cap_hi_q <= cap_lo_q;
        duty_lat_q <= uctrl_q[5:4];
      end
      // prescaler clears when off or outside capture
      if (!is_cap || mode == `CCPU_M_OFF)
        cap_pre_q <= 4'h0;
      else if (rise)
        cap_pre_q <= cap_pre_q + 4'h1;
    end
  end
  // flags: hardware set wins over software clear
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_q <= 2'h0;
      enables_q <= 2'h0;
    end else begin
      if (wr_in && addr_in == `CCPU_OFF_ENABLES)
        enables_q <= wdata_in[2:1];
      flags_q[1] <= (wr_flags ? wdata_in[`CCPU_FLAG_UNIT] : flags_q[1])
        | (is_cap && cap_evt) | cmp_hit;
      flags_q[0] <= (wr_flags ? wdata_in[`CCPU_FLAG_TIMER] : flags_q[0])
        | post_done;
    end
  end
  // output latch: off mode forces low
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_q <= 1'b0;
    end else if (mode == `CCPU_M_OFF) begin
      pin_q <= 1'b0;
    end else if (is_pwm) begin
      if (match)
        pin_q <= !duty_zero;
      else if (tick && (pwm_pos + 10'h001 == duty_now))
        pin_q <= 1'b0;
    end else if (cmp_hit && mode == `CCPU_M_CMP_HIGH) begin
      pin_q <= 1'b1;
    end else if (cmp_hit && mode == `CCPU_M_CMP_LOW) begin
      pin_q <= 1'b0;
    end else if (is_cmp && last_mode_q != mode) begin
      pin_q <= pin_q; // soft and trigger modes leave the pin alone
    end
  end
  // registered outputs and read port
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
      pin_out <= 1'b0;
      wide_timer_reset_out <= 1'b0;
      adc_start_out <= 1'b0;
      unit_event_flag_out <= 1'b0;
      periodic_timer_flag_out <= 1'b0;
    end else begin
      pin_out <= pin_q;
      wide_timer_reset_out <= trig;
      adc_start_out <= trig;
      unit_event_flag_out <= flags_q[1];
      periodic_timer_flag_out <= flags_q[0];
      rdata_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `CCPU_OFF_FLAGS: rdata_out <= {5'h00, flags_q, 1'b0};
          `CCPU_OFF_TCOUNT: rdata_out <= count_q;
          `CCPU_OFF_TCTRL: rdata_out <= {1'b0, tctrl_q};
          `CCPU_OFF_CAPLO: rdata_out <= cap_lo_q;
          `CCPU_OFF_CAPHI: rdata_out <= cap_hi_q;
          `CCPU_OFF_UCTRL: rdata_out <= {2'b00, uctrl_q};
          `CCPU_OFF_ENABLES: rdata_out <= {5'h00, enables_q, 1'b0};
          `CCPU_OFF_PERIOD: rdata_out <= period_q;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule

// File: testbench/ccpu_chk.sv
`timescale 1ns/1ps
module ccpu_chk (
  input wire logic ref_clk_in, // seen
  input wire logic reset_in, // seen
  input wire logic [7:0] addr_in, // seen
  input wire logic [7:0] wdata_in, // seen
  input wire logic wr_in, // seen
  input wire logic rd_in, // seen
  input wire logic [7:0] rdata_out, // seen
  input wire logic pin_in, // seen
  input wire logic pin_out, // seen
  input wire logic wide_timer_reset_out, // seen
  input wire logic adc_start_out, // seen
  input wire logic unit_event_flag_out, // seen
  input wire logic periodic_timer_flag_out // seen
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic [3:0] mode_q;
  logic run_q;
  // shadow of mode and run bits, rebuilt from bus writes
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_q <= 4'h0;
      run_q <= 1'b0;
    end else if (wr_in && addr_in == 8'h17) mode_q <= wdata_in[3:0];
    else if (wr_in && addr_in == 8'h12) run_q <= wdata_in[2];
  end
  tctrl_top_a: assert property (
    $past(rd_in && addr_in == 8'h12) |-> !rdata_out[7]) else $error("t7");
  uctrl_top_a: assert property (
    $past(rd_in && addr_in == 8'h17) |-> rdata_out[7:6] == 2'b00)
    else $error("u76");
  trig_pair_a: assert property (
    wide_timer_reset_out == adc_start_out) else $error("trig pair");
  trig_mode_a: assert property (
    wide_timer_reset_out |-> $past(mode_q) == 4'hB) else $error("trig mode");
  soft_pin_a: assert property (
    $stable(mode_q) && $past(mode_q, 2) == mode_q && mode_q[3:1] == 3'b101
    |-> $stable(pin_out)) else $error("soft pin");
  off_pin_a: assert property (
    $stable(mode_q) && $past(mode_q, 2) == 4'h0 && mode_q == 4'h0
    |-> !pin_out) else $error("off pin");
  cap_flag_a: assert property (
    mode_q == 4'h5 && $rose(pin_in) |-> ##[2:8] unit_event_flag_out)
    else $error("cap flag");
  tflag_run_a: assert property (
    $rose(periodic_timer_flag_out) |-> $past(run_q, 2)) else $error("tflag");
  cover property (wide_timer_reset_out);
  cover property ($rose(pin_out));
  cover property ($rose(unit_event_flag_out));
  cover property ($fell(pin_out) && mode_q[3:2] == 2'b11);
endmodule
bind ccpu_top ccpu_chk u_ccpu_chk (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in),
  .pin_out(pin_out), .wide_timer_reset_out(wide_timer_reset_out),
  .adc_start_out(adc_start_out), .unit_event_flag_out(unit_event_flag_out),
  .periodic_timer_flag_out(periodic_timer_flag_out));

// File: testbench/ccpu_pin_drv.sv
`timescale 1ns/1ps
// far-side pin source: toggles every gap cycles while enabled
module ccpu_pin_drv (
  input wire logic ref_clk_in, // clock
  input wire logic go_in, // toggle enable
  input wire logic [7:0] gap_in, // cycles per level
  output logic pin_out // pin level
);
  logic [7:0] cnt_q = 8'h00;
  logic wrap;
  assign wrap = go_in && (cnt_q == gap_in - 8'h01);
  // a driven input pin keeps its level between bursts
  initial pin_out = 1'b0;
  always @(posedge ref_clk_in) begin
    cnt_q <= (go_in && !wrap) ? cnt_q + 8'h01 : 8'h00;
    if (wrap) pin_out <= ~pin_out;
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, pin, uef, tf, po, trg;
  logic [7:0] a = 0, wd = 0, q, d, d2;
  logic [15:0] wc = 0, v;
  int num_errors = 0, tests_run = 0, seed = 29990, c, e;
  int sl[4] = '{2, 4, 0, 3};
  always #5 clk = ~clk;
  ccpu_top u_ccpu_top (.ref_clk_in(clk), .reset_in(rst), .addr_in(a),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(q), .pin_in(pin),
    .wide_timer_count_in(wc), .pin_out(po), .wide_timer_reset_out(trg),
    .adc_start_out(), .unit_event_flag_out(uef), .periodic_timer_flag_out(tf));
  ccpu_pin_drv u_ccpu_pin_drv (.ref_clk_in(clk), .go_in(go), .gap_in(8'h04),
    .pin_out(pin));
  task close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one-cycle strobes, launched by non-blocking assignment at an edge
  task w(input [7:0] ad, dt);
    @(posedge clk);
    a <= ad;
    wd <= dt;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task r(input [7:0] ad);
    @(posedge clk);
    a <= ad;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 d = q;
  endtask
  task rc(input [7:0] ad, ex);
    r(ad);
    `CK("reg", ex, d)
  endtask
  // bounded wait on one of: flag, timer flag, pin high, trigger, pin low
  task wf(input int k);
    logic [4:0] s;
    tests_run++;
    for (c = 0; c < 400; c++) begin
      @(posedge clk);
      #1 s = {!po, trg, po, tf, uef};
      if (s[k] === 1'b1) return;
    end
    num_errors++;
    $display("[ERR] wait %0d exp done got timeout", k);
    close_out;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rc(8'h92, 8'hFF);
    rc(8'h12, 8'h00);
    rc(8'h17, 8'h00);
    rc(8'h40, 8'h00);
    repeat (4) begin
      v = 16'($random(seed));
      w(8'h12, v[7:0]);
      rc(8'h12, v[7:0] & 8'h7F);
    end
    w(8'h12, 8'h00);
    w(8'h17, 8'hFF);
    rc(8'h17, 8'h3F);
    w(8'h17, 8'h00);
    w(8'h15, 8'hA5);
    w(8'h16, 8'h5A);
    rc(8'h15, 8'hA5);
    rc(8'h16, 8'h5A);
    // two matches at period 3: the tick spacing shows the prescale
    w(8'h92, 8'h03);
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 1 : (i == 1) ? 4 : 16;
      w(8'h12, 8'h00);
      w(8'h11, 8'h00);
      w(8'h0C, 8'h00);
      w(8'h12, 8'h0C | i[7:0]);
      wf(1);
      `CK("ticks", 1'b1, c >= 6 * e && c <= 8 * e + 6)
    end
    repeat (6) begin
      r(8'h11);
      `CK("count", 1'b1, d <= 8'h03)
    end
    w(8'h12, 8'h00);
    r(8'h11);
    d2 = d;
    repeat (5) @(posedge clk);
    rc(8'h11, d2);
    for (int m = 4; m < 8; m++) begin
      w(8'h17, 8'h00);
      w(8'h0C, 8'h00);
      wc <= 16'($random(seed));
      w(8'h17, m[7:0]);
      go <= 1;
      wf(0);
      go <= 0;
      `CK("events", 1'b1, c >= (m == 7 ? 112 : m == 6 ? 24 : 0))
      r(8'h15);
      d2 = d;
      r(8'h16);
      `CK("capture", wc, {d, d2})
    end
    w(8'h17, 8'h00);
    v = 16'($random(seed));
    wc <= ~v;
    w(8'h15, v[7:0]);
    w(8'h16, v[15:8]);
    for (int m = 8; m < 12; m++) begin
      w(8'h0C, 8'h00);
      w(8'h17, m[7:0]);
      wc <= v;
      wf(sl[m - 8]);
      wc <= ~v;
      repeat (2) @(posedge clk);
      `CK("match flag", 1'b1, uef)
    end
    // zero duty must never raise the pin
    w(8'h17, 8'h00);
    w(8'h15, 8'h00);
    w(8'h12, 8'h04);
    w(8'h17, 8'h0C);
    repeat (8) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1 `CK("pwm zero", 1'b0, po)
    end
    w(8'h15, 8'h02);
    w(8'h17, 8'h1F);
    wf(2);
    wf(4);
    close_out;
  end
endmodule
